// file: verilog/pbsr_pkg.sv
package pbsr_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] PBSR_OFF_STATUS = 8'h06;
   localparam logic [7:0] PBSR_OFF_CMD = 8'h04;
   localparam logic [15:0] PBSR_STATUS_RESET = 16'h0010;
   localparam logic [15:0] PBSR_CMD_RESET = 16'h0000;
   // ---------------------------------------------------------------
   // Status field positions
   // ---------------------------------------------------------------
   localparam int PBSR_B_POISONED_RX = 15;
   localparam int PBSR_B_ERR_MSG_SENT = 14;
   localparam int PBSR_B_UNSUPP_REQ_CPL = 13;
   localparam int PBSR_B_ABORT_CPL_RX = 12;
   localparam int PBSR_B_ABORT_CPL_TX = 11;
   localparam int PBSR_B_DATA_POISON = 8;
   localparam int PBSR_B_CAP_LIST = 4;
   // Sticky flag mask: bits 15..11 and 8
   localparam logic [15:0] PBSR_FLAG_MASK = 16'hf900;
   localparam logic [15:0] PBSR_CONST_BITS = 16'h0010;
   // ---------------------------------------------------------------
   // Command field positions
   // ---------------------------------------------------------------
   localparam int PBSR_B_POISON_REPORT_EN = 6;
   localparam int PBSR_B_ERR_MSG_EN = 8;
   // Writable command bits: 8,6,4,2,1,0
   localparam logic [15:0] PBSR_CMD_WMASK = 16'h0157;
   localparam int PBSR_NUM_FLAGS = 6;
endpackage

// file: verilog/pbsr_flag_cell.sv
`timescale 1ns/10ps
// One sticky flag; set wins over a write-one clear
module pbsr_flag_cell
   import pbsr_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_set,
   input wire logic i_clear,
   output logic o_flag
);
   logic next_flag;

   always_comb begin
      next_flag = o_flag;
      if (i_clear) begin
         next_flag = 1'b0;
      end
      if (i_set) begin
         next_flag = 1'b1;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_flag <= 1'b0;
      end else begin
         o_flag <= next_flag;
      end
   end
endmodule

// file: verilog/pbsr_status_word.sv
`timescale 1ns/10ps
//
// Contract
// - The status word is a 16-bit config register at offset 06h.
// - Bit 15 sets on any received poisoned TLP, regardless of enables.
// - Bit 14 sets on an ERR_FATAL/NONFATAL send while error-msg enable.
// - Bit 13 sets on a received unsupported-request completion.
// - Bit 12 sets on a received completer-abort completion.
// - Bit 11 sets when the device returns completer-abort status.
// - Bits 10:9 always read as zero.
// - Bit 8 sets only with poison-report enable on a poisoned cpl or write.
// - Bit 7 always reads as zero.
// - Bit 5 always reads as zero.
// - Bit 4 always reads one, so the word resets to 0010h.
// - Bit 3 always reads as zero.
// - Bits 6 and 2:0 read zero and ignore writes.
// - Poison-report enable is command bit 6; clear blocks bit 8.
// - Error-message enable is command bit 8, resetting to zero.
module pbsr_status_word
   import pbsr_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_cfg_wr,
   input wire logic i_cfg_rd,
   input wire logic [7:0] i_cfg_addr,
   input wire logic [15:0] i_cfg_wdata,
   output logic [15:0] o_cfg_rdata,
   input wire logic i_poisoned_tlp_rx,
   input wire logic i_err_msg_tx,
   input wire logic i_unsupp_req_cpl_rx,
   input wire logic i_abort_cpl_rx,
   input wire logic i_abort_cpl_tx,
   input wire logic i_poisoned_cpl_data_rx,
   input wire logic i_write_poisoned,
   output logic [15:0] o_status,
   output logic o_poison_report_enable,
   output logic o_error_msg_enable
);
   // ---------------------------------------------------------------
   // Command register (only bits 8,6,4,2,1,0 are kept live; this block uses 8 and 6)
   // ---------------------------------------------------------------
   logic [15:0] cmd;
   logic [15:0] next_cmd;
   logic wr_cmd;
   logic wr_status;

   assign wr_cmd = i_cfg_wr && (i_cfg_addr == PBSR_OFF_CMD);
   assign wr_status = i_cfg_wr && (i_cfg_addr == PBSR_OFF_STATUS);

   always_comb begin
      next_cmd = cmd;
      if (wr_cmd) begin
         next_cmd = i_cfg_wdata & PBSR_CMD_WMASK;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cmd <= PBSR_CMD_RESET;
      end else begin
         cmd <= next_cmd;
      end
   end

   assign o_poison_report_enable = cmd[PBSR_B_POISON_REPORT_EN];
   assign o_error_msg_enable = cmd[PBSR_B_ERR_MSG_EN];

   // ---------------------------------------------------------------
   // Sticky flags
   // ---------------------------------------------------------------
   logic [PBSR_NUM_FLAGS-1:0] set_vec;
   logic [PBSR_NUM_FLAGS-1:0] clr_vec;
   logic [PBSR_NUM_FLAGS-1:0] flag_vec;

   assign set_vec[5] = i_poisoned_tlp_rx;
   assign set_vec[4] = i_err_msg_tx && o_error_msg_enable;
   assign set_vec[3] = i_unsupp_req_cpl_rx;
   assign set_vec[2] = i_abort_cpl_rx;
   assign set_vec[1] = i_abort_cpl_tx;
   assign set_vec[0] = o_poison_report_enable
      && (i_poisoned_cpl_data_rx || i_write_poisoned);

   assign clr_vec = {
      wr_status && i_cfg_wdata[PBSR_B_POISONED_RX],
      wr_status && i_cfg_wdata[PBSR_B_ERR_MSG_SENT],
      wr_status && i_cfg_wdata[PBSR_B_UNSUPP_REQ_CPL],
      wr_status && i_cfg_wdata[PBSR_B_ABORT_CPL_RX],
      wr_status && i_cfg_wdata[PBSR_B_ABORT_CPL_TX],
      wr_status && i_cfg_wdata[PBSR_B_DATA_POISON]};

   genvar g;
   generate
      for (g = 0; g < PBSR_NUM_FLAGS; g++) begin : g_flag
         // Set beats clear inside the cell
         pbsr_flag_cell u_cell (
            .i_clock(i_clock),
            .i_rst(i_rst),
            .i_set(set_vec[g]),
            .i_clear(clr_vec[g]),
            .o_flag(flag_vec[g])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Status word assembly
   // ---------------------------------------------------------------
   logic [15:0] status_word;
   always_comb begin
      status_word = PBSR_CONST_BITS;
      status_word[PBSR_B_POISONED_RX] = flag_vec[5];
      status_word[PBSR_B_ERR_MSG_SENT] = flag_vec[4];
      status_word[PBSR_B_UNSUPP_REQ_CPL] = flag_vec[3];
      status_word[PBSR_B_ABORT_CPL_RX] = flag_vec[2];
      status_word[PBSR_B_ABORT_CPL_TX] = flag_vec[1];
      status_word[PBSR_B_DATA_POISON] = flag_vec[0];
      status_word[PBSR_B_CAP_LIST] = 1'b1;
   end
   assign o_status = status_word;

   // ---------------------------------------------------------------
   // Read port; data held in a flop, unmapped reads return zero
   // ---------------------------------------------------------------
   logic [15:0] next_rdata;
   always_comb begin
      next_rdata = o_cfg_rdata;
      if (i_cfg_rd) begin
         if (i_cfg_addr == PBSR_OFF_STATUS) begin
            next_rdata = status_word;
         end else if (i_cfg_addr == PBSR_OFF_CMD) begin
            next_rdata = cmd;
         end else begin
            next_rdata = 16'h0000;
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_cfg_rdata <= 16'h0000;
      end else begin
         o_cfg_rdata <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_POISON_ANY: assert property (@(posedge i_clock) disable iff (i_rst)
      i_poisoned_tlp_rx |=> o_status[15])
      else $error("poisoned rx flag not set");
   AST_ERRMSG_GATED: assert property (@(posedge i_clock) disable iff (i_rst)
      (!o_status[14] && !(i_err_msg_tx && o_error_msg_enable))
      |=> !o_status[14])
      else $error("err msg flag set without enable");
   AST_ERRMSG_SET: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_err_msg_tx && o_error_msg_enable) |=> o_status[14])
      else $error("err msg flag missed");
   AST_UR_SET: assert property (@(posedge i_clock) disable iff (i_rst)
      i_unsupp_req_cpl_rx |=> o_status[13])
      else $error("unsupported cpl flag missed");
   AST_CA_RX_SET: assert property (@(posedge i_clock) disable iff (i_rst)
      i_abort_cpl_rx |=> o_status[12])
      else $error("abort cpl rx flag missed");
   AST_CA_TX_SET: assert property (@(posedge i_clock) disable iff (i_rst)
      i_abort_cpl_tx |=> o_status[11])
      else $error("abort cpl tx flag missed");
   AST_CONST_BITS: assert property (@(posedge i_clock) disable iff (i_rst)
      (o_status & 16'h06ff) == 16'h0010)
      else $error("constant bits wrong");
   AST_DP_GATED: assert property (@(posedge i_clock) disable iff (i_rst)
      (!o_status[8] && !o_poison_report_enable) |=> !o_status[8])
      else $error("data poison set while disabled");
   AST_CLEAR: assert property (@(posedge i_clock) disable iff (i_rst)
      (wr_status && i_cfg_wdata[12] && !i_abort_cpl_rx) |=> !o_status[12])
      else $error("write one did not clear");
   AST_STICKY: assert property (@(posedge i_clock) disable iff (i_rst)
      (o_status[13] && !(wr_status && i_cfg_wdata[13])) |=> o_status[13])
      else $error("flag dropped without clear");
   AST_READ: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_cfg_rd && i_cfg_addr == 8'h06 && !i_cfg_wr) |=>
      o_cfg_rdata == $past(o_status))
      else $error("read data mismatch");

   COV_POISON: cover property (@(posedge i_clock) disable iff (i_rst)
      i_poisoned_tlp_rx ##1 o_status[15]);
   COV_SET_CLEAR_SAME: cover property (@(posedge i_clock)
      disable iff (i_rst) i_abort_cpl_tx && wr_status && i_cfg_wdata[11]);
   COV_DP: cover property (@(posedge i_clock) disable iff (i_rst)
      set_vec[0] ##1 o_status[8]);
endmodule

// file: test/pbsr_host_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Upstream config host
// ---------------------------------------------------------------
module pbsr_host_model (
   input wire logic i_clock,
   output logic o_cfg_wr,
   output logic o_cfg_rd,
   output logic [7:0] o_cfg_addr,
   output logic [15:0] o_cfg_wdata
);
   initial begin
      o_cfg_wr = 1'b0;
      o_cfg_rd = 1'b0;
      o_cfg_addr = 8'h00;
      o_cfg_wdata = 16'h0000;
   end
   // Idle bus is inverted so a stale mapped address never stays on the bus
   task automatic access(input logic wr, input logic [7:0] a,
         input logic [15:0] d);
      @(posedge i_clock);
      o_cfg_wr <= wr;
      o_cfg_rd <= !wr;
      o_cfg_addr <= a;
      o_cfg_wdata <= d;
      @(posedge i_clock);
      o_cfg_wr <= 1'b0;
      o_cfg_rd <= 1'b0;
      o_cfg_addr <= ~a;
      o_cfg_wdata <= ~d;
   endtask
endmodule

// file: test/pcie_bridge_status_register_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
   failures++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module pcie_bridge_status_register_tb_top;
   import pbsr_pkg::*;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic wr, rd;
   logic [7:0] addr;
   logic [15:0] wdata, o_cfg_rdata, o_status, exp, cmd;
   logic [6:0] ev = 7'h00;
   logic o_poison_report_enable, o_error_msg_enable;
   logic [31:0] seed = 32'h49cf8ff2;
   int failures = 0;
   int num_checks = 0;
   always #2.5 i_clock = ~i_clock;
   pbsr_host_model pbsr_host_model_inst (.i_clock(i_clock), .o_cfg_wr(wr),
      .o_cfg_rd(rd), .o_cfg_addr(addr), .o_cfg_wdata(wdata));
   pbsr_status_word pbsr_status_word_inst (.i_clock(i_clock),
      .i_rst(i_rst), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr),
      .i_cfg_wdata(wdata), .o_cfg_rdata(o_cfg_rdata),
      .i_poisoned_tlp_rx(ev[6]), .i_err_msg_tx(ev[5]),
      .i_unsupp_req_cpl_rx(ev[4]), .i_abort_cpl_rx(ev[3]),
      .i_abort_cpl_tx(ev[2]), .i_poisoned_cpl_data_rx(ev[1]),
      .i_write_poisoned(ev[0]), .o_status(o_status),
      .o_poison_report_enable(o_poison_report_enable),
      .o_error_msg_enable(o_error_msg_enable));
   // ---------------------------------------------------------------
   // Reference model
   // ---------------------------------------------------------------
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         exp <= PBSR_STATUS_RESET;
         cmd <= PBSR_CMD_RESET;
      end else begin
         // Set after clear, so a same-cycle event keeps the flag
         exp <= (exp & ~((wr && addr == PBSR_OFF_STATUS) ?
            wdata & PBSR_FLAG_MASK : 16'h0000)) | {ev[6], ev[5] & cmd[8],
            ev[4], ev[3], ev[2], 2'b00, (ev[1] | ev[0]) & cmd[6], 8'h00};
         if (wr && addr == PBSR_OFF_CMD) begin
            cmd <= wdata & PBSR_CMD_WMASK;
         end
      end
   end
   always @(negedge i_clock) begin
      if (!i_rst) begin
         `CHK(o_status, exp)
         `CHK({o_error_msg_enable, o_poison_report_enable},
            {cmd[8], cmd[6]})
      end
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] exp_read(input logic [7:0] a);
      return (a == PBSR_OFF_STATUS) ? exp :
         (a == PBSR_OFF_CMD) ? cmd : 16'h0000;
   endfunction
   task automatic rd_chk(input logic [7:0] a);
      logic [15:0] e;
      pbsr_host_model_inst.access(1'b0, a, 16'h0000);
      e = exp_read(a);
      #1;
      `CHK(o_cfg_rdata, e)
   endtask
   task automatic ev_all(input logic [15:0] c);
      pbsr_host_model_inst.access(1'b1, PBSR_OFF_CMD, c);
      ev <= 7'h7f;
      pbsr_host_model_inst.access(1'b1, PBSR_OFF_STATUS, 16'hffff);
      ev <= 7'h00;
      rd_chk(PBSR_OFF_STATUS);
      `CHK(o_cfg_rdata & 16'h06ff, 16'h0010)
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      stop_test();
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic [31:0] w;
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
      rd_chk(PBSR_OFF_STATUS);
      rd_chk(PBSR_OFF_CMD);
      ev_all(16'h0000);
      pbsr_host_model_inst.access(1'b1, PBSR_OFF_STATUS, 16'hffff);
      ev_all(16'hffff);
      pbsr_host_model_inst.access(1'b1, 8'h08, 16'hffff);
      rd_chk(8'h02);
      rd_chk(PBSR_OFF_CMD);
      for (int i = 0; i < 3000; i++) begin
         @(posedge i_clock);
         r = xs();
         ev <= r[6:0] & r[13:7] & r[20:14];
         if (r[23:21] == 3'h0) begin
            w = xs();
            pbsr_host_model_inst.access(1'b1, r[24] ? PBSR_OFF_STATUS :
               PBSR_OFF_CMD, w[15:0]);
         end else if (r[23:21] == 3'h1) begin
            rd_chk(r[25] ? PBSR_OFF_STATUS : (r[26] ? PBSR_OFF_CMD :
               r[31:24]));
         end
      end
      ev <= 7'h7f;
      @(posedge i_clock);
      i_rst <= 1'b1;
      #1;
      `CHK(o_status, PBSR_STATUS_RESET)
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
      ev <= 7'h00;
      rd_chk(PBSR_OFF_STATUS);
      stop_test();
   end
endmodule
